// file: hw/sic_sysctl.sv
// Design decision made here: the Wishbone interface to the registers.
`include "sic_consts.svh"
// How it works
// [RQ1] Masked bit is raw AND mask, and bit 1 also needs select clear; any masked bit raises the interrupt.
// [RQ2] Writing one to a masked bit clears it and its raw bit.
// [RQ3] Bit 6 sets on loop ready timer expiry when its mask is set.
// [RQ4] Bit 5 sets on regulator current limit when its mask is set.
// [RQ5] Bit 4 sets on internal oscillator fault when its mask is set.
// [RQ6] Bit 3 sets on main oscillator fault when its mask is set.
// [RQ7] Bit 2 sets on unregulated regulator output when masked in.
// [RQ8] Brown-out bit 1 interrupts only with mask set and select clear.
// [RQ9] Bit 0 sets when the loop stops oscillating and its mask is set.
// [RQ10] Reset-cause value comes from the reset source, not a constant.
// [RQ11] External pin reset sets bit 0 and clears all other causes.
// [RQ12] Other reset sources set their flag and keep earlier flags; power-on instead loads only the sources seen in its own pulse.
// [RQ13] Cause bit 5 power-good lost, bit 4 software, bit 3 watchdog.
// [RQ14] Cause bit 2 brown-out, bit 1 power-on, bit 0 external pin.
// [RQ15] A clear mask bit keeps its event from causing an interrupt.
// [RQ16] Software may overwrite every cause flag, ideally to zero.
// [RQ17] Reserved upper bits ignore writes and read as zero.
module sic_sysctl (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Raw event sources, high while the condition holds, then the brown-out interrupt-or-reset select
  input wire logic loop_ready_i,
  input wire logic cur_limit_i,
  input wire logic int_osc_fault_i,
  input wire logic main_osc_fault_i,
  input wire logic reg_unreg_i,
  input wire logic brownout_i,
  input wire logic loop_fault_i,
  input wire logic brownout_irq_or_reset_select_i,
  // Reset sources, sampled while rst_i is high
  input wire logic ext_reset_i,
  input wire logic power_on_reset_i,
  input wire logic brownout_reset_i,
  input wire logic watchdog_reset_i,
  input wire logic software_reset_i,
  input wire logic power_good_lost_i,
  // Interrupt and status
  output logic irq_o,
  output logic [6:0] masked_status_o
);

  sic_pkg::sic_evt_t raw_event_status;
  sic_pkg::sic_evt_t event_mask_control;
  sic_pkg::sic_cause_t reset_cause_log;
  sic_pkg::sic_cause_t cause_seen;
  logic rst_q;

  // Bus decode; a write lands on the edge where ack is high
  wire logic req = cyc_i && stb_i;
  wire logic wr_go = req && we_i && ack_o && sel_i[0];
  wire logic hit_raw = adr_i == `SIC_RAW_OFS;
  wire logic hit_mask = adr_i == `SIC_MASK_OFS;
  wire logic hit_misc = adr_i == `SIC_MISC_OFS;
  wire logic hit_cause = adr_i == `SIC_CAUSE_OFS;
  wire logic mask_wr = wr_go && hit_mask;
  wire logic misc_wr = wr_go && hit_misc;
  wire logic cause_wr = wr_go && hit_cause;

  // Event vector in register bit order
  wire sic_pkg::sic_evt_t evt_in = {loop_ready_i, cur_limit_i,
    int_osc_fault_i, main_osc_fault_i, reg_unreg_i, brownout_i,
    loop_fault_i}; // RQ3 RQ4 RQ5 RQ6 RQ7 RQ9

  // Brown-out only interrupts when it is not routed to reset
  wire sic_pkg::sic_evt_t evt_gate = ~(sic_pkg::sic_evt_t'(
    brownout_irq_or_reset_select_i) << `SIC_BIT_BROWNOUT); // RQ8
  wire sic_pkg::sic_evt_t masked =
    raw_event_status & event_mask_control & evt_gate; // RQ1 RQ15

  // Only the low byte carries fields; upper bits are dropped
  wire sic_pkg::sic_evt_t w1c_clr =
    misc_wr ? dat_i[`SIC_EVT_W-1:0] : `SIC_EVT_RST; // RQ2 RQ17

  // Reset sources in cause-register order
  wire sic_pkg::sic_cause_t cause_in = {power_good_lost_i,
    software_reset_i, watchdog_reset_i, brownout_reset_i,
    power_on_reset_i, ext_reset_i}; // RQ13 RQ14

  // Read mux; unmapped offsets and reserved bits read zero
  wire logic [31:0] rd_mux =
    hit_raw ? {25'h0000000, raw_event_status} :
    hit_mask ? {25'h0000000, event_mask_control} :
    hit_misc ? {25'h0000000, masked} :
    hit_cause ? {26'h0000000, reset_cause_log} :
    32'h00000000; // RQ17

  // A new event wins over a same-cycle clear so it is never lost
  wire sic_pkg::sic_evt_t next_raw =
    (raw_event_status & ~w1c_clr) | evt_in; // RQ2

  // External pin wipes history; power-on keeps only its own pulse; others pile up on what was there
  wire sic_pkg::sic_cause_t next_cause =
    cause_seen[`SIC_CAUSE_EXTERNAL] ?
      sic_pkg::sic_cause_t'(1'b1 << `SIC_CAUSE_EXTERNAL) : // RQ11
    cause_seen[`SIC_CAUSE_POWER_ON] ? cause_seen :
      reset_cause_log | cause_seen; // RQ12

  // Single-wait-state slave: ack one cycle after the request
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h00000000;
    end else begin
      ack_o <= req && !ack_o;
      dat_o <= rd_mux;
    end
  end

  // Raw status and mask
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      raw_event_status <= `SIC_EVT_RST;
      event_mask_control <= `SIC_EVT_RST;
    end else begin
      raw_event_status <= next_raw; // RQ2
      if (mask_wr) begin
        event_mask_control <= dat_i[`SIC_EVT_W-1:0]; // RQ15 RQ17
      end
    end
  end

  // Gather every source seen during the reset pulse; a power-on
  // sample starts afresh, since nothing held before it can be trusted
  always_ff @(posedge ref_clk_i) begin
    rst_q <= rst_i;
    if (!rst_i) begin
      cause_seen <= `SIC_CAUSE_RST; // Ready for the next pulse
    end else if (power_on_reset_i) begin
      cause_seen <= cause_in;
    end else begin
      cause_seen <= cause_seen | cause_in;
    end
  end

  // The log is never cleared by reset itself; it loads from the
  // sources at the first edge after release
  always_ff @(posedge ref_clk_i) begin
    if (rst_q && !rst_i) begin
      reset_cause_log <= next_cause; // RQ10
    end else if (cause_wr) begin
      reset_cause_log <= dat_i[`SIC_CAUSE_W-1:0]; // RQ16 RQ17
    end
  end

  // Interrupt level and flag outputs, registered
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
      masked_status_o <= `SIC_EVT_RST;
    end else begin
      irq_o <= |(next_raw & event_mask_control & evt_gate); // RQ1
      masked_status_o <= next_raw & event_mask_control & evt_gate;
    end
  end

  // Interrupt path checks. irq_o and masked_status_o are registered
  // from next state, so they lag a mask or select change by one edge;
  // those edges are left out of the equality checks on purpose.
  a_irq_follows: assert property ( // RQ1
    @(posedge ref_clk_i) disable iff (rst_i)
    !$past(rst_i) && $stable(event_mask_control)
      && $stable(brownout_irq_or_reset_select_i)
    |-> irq_o == (|masked))
    else $error("irq does not match masked status");

  a_misc_view: assert property ( // RQ1
    @(posedge ref_clk_i) disable iff (rst_i)
    !$past(rst_i) && $stable(event_mask_control)
      && $stable(brownout_irq_or_reset_select_i)
    |-> masked_status_o == masked)
    else $error("masked status output wrong");

  // The request can only come from an event that was let through
  a_irq_needs_mask: assert property ( // RQ15
    @(posedge ref_clk_i) disable iff (rst_i)
    irq_o |-> (|$past(event_mask_control)))
    else $error("irq raised with every mask bit clear");

  // Reads of the masked view return what stood a cycle before ack
  a_misc_read: assert property ( // RQ1
    @(posedge ref_clk_i) disable iff (rst_i)
    ack_o && $past(hit_misc)
    |-> dat_o[`SIC_EVT_W-1:0] == $past(masked))
    else $error("masked status read wrong");

  // Write-one-to-clear behaviour
  a_w1c_clears: assert property ( // RQ2
    @(posedge ref_clk_i) disable iff (rst_i)
    misc_wr && dat_i[`SIC_BIT_LOOP_FAULT] && !loop_fault_i
    |=> !raw_event_status[`SIC_BIT_LOOP_FAULT])
    else $error("write one did not clear raw bit");

  a_w1c_all: assert property ( // RQ2
    @(posedge ref_clk_i) disable iff (rst_i)
    misc_wr && dat_i[`SIC_EVT_W-1:0] == 7'h7F
      && evt_in == `SIC_EVT_RST
    |=> raw_event_status == `SIC_EVT_RST)
    else $error("clear of all bits left a raw bit");

  a_w0_keeps: assert property ( // RQ2
    @(posedge ref_clk_i) disable iff (rst_i)
    misc_wr && !dat_i[`SIC_BIT_CUR_LIMIT] |=>
    raw_event_status[`SIC_BIT_CUR_LIMIT] ==
      $past(raw_event_status[`SIC_BIT_CUR_LIMIT])
      || $past(cur_limit_i))
    else $error("write zero changed a bit");

  // Without a clear write no recorded bit may fall
  a_no_wr_keeps: assert property ( // RQ2
    @(posedge ref_clk_i) disable iff (rst_i)
    !misc_wr |=> (raw_event_status & $past(raw_event_status))
      == $past(raw_event_status))
    else $error("raw bit lost without a clear");

  // Each event, when let through, shows up one edge later
  a_ready_sets: assert property ( // RQ3
    @(posedge ref_clk_i) disable iff (rst_i)
    loop_ready_i && event_mask_control[`SIC_BIT_LOOP_READY] && !mask_wr
    |=> masked_status_o[`SIC_BIT_LOOP_READY] && irq_o)
    else $error("loop ready event lost");

  a_climit_sets: assert property ( // RQ4
    @(posedge ref_clk_i) disable iff (rst_i)
    cur_limit_i && event_mask_control[`SIC_BIT_CUR_LIMIT] && !mask_wr
    |=> masked[`SIC_BIT_CUR_LIMIT])
    else $error("current limit event lost");

  a_iosc_sets: assert property ( // RQ5
    @(posedge ref_clk_i) disable iff (rst_i)
    int_osc_fault_i && event_mask_control[`SIC_BIT_INT_OSC] && !mask_wr
    |=> masked[`SIC_BIT_INT_OSC])
    else $error("internal oscillator event lost");

  a_mosc_sets: assert property ( // RQ6
    @(posedge ref_clk_i) disable iff (rst_i)
    main_osc_fault_i && event_mask_control[`SIC_BIT_MAIN_OSC] && !mask_wr
    |=> masked[`SIC_BIT_MAIN_OSC])
    else $error("main oscillator event lost");

  a_unreg_sets: assert property ( // RQ7
    @(posedge ref_clk_i) disable iff (rst_i)
    reg_unreg_i && event_mask_control[`SIC_BIT_REG_UNREG] && !mask_wr
    |=> masked[`SIC_BIT_REG_UNREG])
    else $error("unregulated event lost");

  // Brown-out needs the mask and a select that keeps it off reset
  a_bor_sets: assert property ( // RQ8
    @(posedge ref_clk_i) disable iff (rst_i)
    brownout_i && event_mask_control[`SIC_BIT_BROWNOUT] && !mask_wr
      && !brownout_irq_or_reset_select_i
    |=> masked_status_o[`SIC_BIT_BROWNOUT])
    else $error("brown-out event lost");

  a_bor_gated: assert property ( // RQ8
    @(posedge ref_clk_i) disable iff (rst_i)
    brownout_irq_or_reset_select_i |-> !masked[`SIC_BIT_BROWNOUT])
    else $error("brown-out interrupt while routed to reset");

  a_lfault_sets: assert property ( // RQ9
    @(posedge ref_clk_i) disable iff (rst_i)
    loop_fault_i && event_mask_control[`SIC_BIT_LOOP_FAULT] && !mask_wr
    |=> masked[`SIC_BIT_LOOP_FAULT])
    else $error("loop fault event lost");

  // Masking hides an event from the request but not from the record
  a_raw_records: assert property ( // RQ15
    @(posedge ref_clk_i) disable iff (rst_i)
    evt_in != `SIC_EVT_RST
    |=> (raw_event_status & $past(evt_in)) == $past(evt_in))
    else $error("raw status missed an event");

  a_mask_blocks: assert property ( // RQ15
    @(posedge ref_clk_i) disable iff (rst_i)
    event_mask_control == `SIC_EVT_RST |-> !(|masked))
    else $error("event passed a clear mask");

  a_mask_write: assert property ( // RQ15
    @(posedge ref_clk_i) disable iff (rst_i)
    mask_wr |=> event_mask_control == $past(dat_i[`SIC_EVT_W-1:0]))
    else $error("mask write did not land");

  // Reset-release cause checks run through reset, so they carry no disable
  a_ext_wipes: assert property ( // RQ11
    @(posedge ref_clk_i)
    rst_q && !rst_i && cause_seen[`SIC_CAUSE_EXTERNAL]
    |=> reset_cause_log == 6'h01)
    else $error("external reset kept old causes");

  a_cause_piles: assert property ( // RQ12
    @(posedge ref_clk_i)
    rst_q && !rst_i && !cause_seen[`SIC_CAUSE_EXTERNAL]
      && !cause_seen[`SIC_CAUSE_POWER_ON]
    |=> reset_cause_log == ($past(reset_cause_log) | $past(cause_seen)))
    else $error("reset causes did not accumulate");

  a_por_fresh: assert property ( // RQ10
    @(posedge ref_clk_i)
    rst_q && !rst_i && !cause_seen[`SIC_CAUSE_EXTERNAL]
      && cause_seen[`SIC_CAUSE_POWER_ON]
    |=> reset_cause_log == $past(cause_seen))
    else $error("power-on cause not loaded fresh");

  a_cause_write: assert property ( // RQ16
    @(posedge ref_clk_i) disable iff (rst_i)
    cause_wr && !(rst_q && !rst_i)
    |=> reset_cause_log == $past(dat_i[`SIC_CAUSE_W-1:0]))
    else $error("cause log write did not land");

  a_cause_read: assert property ( // RQ10
    @(posedge ref_clk_i) disable iff (rst_i)
    ack_o && $past(hit_cause)
    |-> dat_o[`SIC_CAUSE_W-1:0] == $past(reset_cause_log))
    else $error("cause log read wrong");

  // Bus handshake; writes and clears rely on this timing
  a_ack_timing: assert property ( // RQ2
    @(posedge ref_clk_i) disable iff (rst_i)
    req && !ack_o |=> ack_o)
    else $error("ack did not follow the request");

  a_ack_single: assert property ( // RQ17
    @(posedge ref_clk_i) disable iff (rst_i)
    ack_o |=> !ack_o)
    else $error("ack held for more than one cycle");

  a_resv_zero: assert property ( // RQ17
    @(posedge ref_clk_i) disable iff (rst_i)
    ack_o |-> dat_o[31:7] == 25'h0000000)
    else $error("reserved bits read nonzero");

  // Main scenarios that the bench is expected to reach
  c_event_irq: cover property (@(posedge ref_clk_i) disable iff (rst_i)
    !irq_o ##1 irq_o);
  c_w1c_drop: cover property (@(posedge ref_clk_i) disable iff (rst_i)
    irq_o && misc_wr ##1 !irq_o);
  c_ext_reset: cover property (@(posedge ref_clk_i)
    rst_q && !rst_i && cause_seen[`SIC_CAUSE_EXTERNAL]);
  c_sw_accum: cover property (@(posedge ref_clk_i)
    rst_q && !rst_i && cause_seen[`SIC_CAUSE_SOFTWARE]
      && reset_cause_log[`SIC_CAUSE_WATCHDOG]);
  c_bor_routed: cover property (@(posedge ref_clk_i) disable iff (rst_i)
    brownout_i && brownout_irq_or_reset_select_i
      && event_mask_control[`SIC_BIT_BROWNOUT]);

endmodule

// file: hw/sic_consts.svh
`ifndef SIC_CONSTS_SVH
`define SIC_CONSTS_SVH

// Register byte offsets
`define SIC_RAW_OFS 8'h50
`define SIC_MASK_OFS 8'h54
`define SIC_MISC_OFS 8'h58
`define SIC_CAUSE_OFS 8'h5C

// Event bit positions, shared by raw, mask and masked registers
`define SIC_BIT_LOOP_READY 6
`define SIC_BIT_CUR_LIMIT 5
`define SIC_BIT_INT_OSC 4
`define SIC_BIT_MAIN_OSC 3
`define SIC_BIT_REG_UNREG 2
`define SIC_BIT_BROWNOUT 1
`define SIC_BIT_LOOP_FAULT 0

// Reset-cause bit positions
`define SIC_CAUSE_PWR_GOOD 5
`define SIC_CAUSE_SOFTWARE 4
`define SIC_CAUSE_WATCHDOG 3
`define SIC_CAUSE_BROWNOUT 2
`define SIC_CAUSE_POWER_ON 1
`define SIC_CAUSE_EXTERNAL 0

// Field widths and reset values
`define SIC_EVT_W 7
`define SIC_CAUSE_W 6
`define SIC_EVT_RST 7'h00
`define SIC_CAUSE_RST 6'h00

`endif

// file: hw/sic_pkg.sv
package sic_pkg;
  // One bit per system-control event
  typedef logic [6:0] sic_evt_t;
  // One bit per reset source
  typedef logic [5:0] sic_cause_t;
endpackage

// file: test/sic_irq_model.sv
module sic_irq_model (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // Level request from the block
  input wire logic irq_i,
  // Entries taken by the core
  output int entries_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic irq_seen;
  // A core enters once per rising level; a held level is one entry
  always_ff @(posedge ref_clk_i) begin
    irq_seen <= irq_i;
    if (rst_i) begin
      entries_o <= 0;
    end else if (irq_i && !irq_seen) begin
      entries_o <= entries_o + 1;
    end
  end
endmodule

// file: test/test_sysctl_irq_status_reset_cause.sv
module test_sysctl_irq_status_reset_cause;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic sel_bor = 1'b0;
  logic ack_o;
  logic irq_o;
  logic [3:0] sel = 4'hF;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic [31:0] dat_o;
  logic [6:0] evt = 7'h00;
  logic [6:0] masked;
  // Power-on source held through the first reset
  logic [5:0] cause = 6'h02;
  int bad_count = 0;
  int samples_checked = 0;
  int entries;
  localparam logic [5:0] SRC [5] = '{6'h08, 6'h30, 6'h04, 6'h01, 6'h02};
  localparam logic [5:0] EXP [5] = '{6'h0A, 6'h3A, 6'h3E, 6'h01, 6'h02};

  sic_sysctl i_sic_sysctl (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
    .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel),
    .dat_i(wdat), .dat_o(dat_o), .ack_o(ack_o),
    .loop_ready_i(evt[6]), .cur_limit_i(evt[5]), .int_osc_fault_i(evt[4]),
    .main_osc_fault_i(evt[3]), .reg_unreg_i(evt[2]),
    .brownout_i(evt[1]), .loop_fault_i(evt[0]),
    .brownout_irq_or_reset_select_i(sel_bor),
    .ext_reset_i(cause[0]), .power_on_reset_i(cause[1]),
    .brownout_reset_i(cause[2]), .watchdog_reset_i(cause[3]),
    .software_reset_i(cause[4]), .power_good_lost_i(cause[5]),
    .irq_o(irq_o), .masked_status_o(masked));
  sic_irq_model i_sic_irq_model (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
    .irq_i(irq_o), .entries_o(entries));

  // Free-running 250 MHz clock
  initial begin
    forever #2 ref_clk_i = ~ref_clk_i;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // Classic cycle; held until ack is sampled, so no latency is assumed
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    rdat = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    chk({31'h0, ack_o}, 32'h1, "bus ack");
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp,
                        input string what);
    wb(1'b0, a, 32'h0);
    chk(rdat, exp, what);
  endtask

  // Sources stay up for the whole reset pulse and drop together with rst_i
  task automatic do_reset(input logic [5:0] c);
    @(posedge ref_clk_i);
    rst_i <= 1'b1;
    cause <= c;
    repeat (3) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    cause <= 6'h00;
    @(posedge ref_clk_i);
  endtask

  // One-cycle event pulse; returns once outputs have settled
  task automatic pulse(input logic [6:0] m);
    @(posedge ref_clk_i);
    evt <= m;
    @(posedge ref_clk_i);
    evt <= 7'h00;
    @(posedge ref_clk_i);
  endtask

  task automatic t_cause();
    rd_chk(8'h5C, 32'h02, "power-on cause");
    for (int i = 0; i < 5; i++) begin
      do_reset(SRC[i]);
      rd_chk(8'h5C, {26'h0, EXP[i]}, "cause log");
    end
    wb(1'b1, 8'h5C, 32'hFFFFFFFF);
    rd_chk(8'h5C, 32'h3F, "cause overwrite");
    wb(1'b1, 8'h5C, 32'h0);
    rd_chk(8'h5C, 32'h0, "cause cleared");
    $display("test reset cause finished");
  endtask

  task automatic t_events();
    logic [6:0] m;
    wb(1'b1, 8'h54, 32'hFFFFFFFF);
    rd_chk(8'h54, 32'h7F, "mask width");
    for (int i = 0; i < 7; i++) begin
      m = 7'h01 << i;
      pulse(m);
      chk({25'h0, masked}, {25'h0, m}, "masked bit");
      chk({31'h0, irq_o}, 32'h1, "irq up");
      wb(1'b1, 8'h58, 32'h0);
      rd_chk(8'h58, {25'h0, m}, "zero write kept");
      wb(1'b1, 8'h58, {25'h0, m});
      rd_chk(8'h50, 32'h0, "raw cleared");
      chk({31'h0, irq_o}, 32'h0, "irq down");
    end
    chk(entries, 32'h7, "core entries");
    $display("test events finished");
  endtask

  task automatic t_gate();
    wb(1'b1, 8'h54, 32'h02);
    pulse(7'h20);
    chk({31'h0, irq_o}, 32'h0, "masked off");
    rd_chk(8'h50, 32'h20, "raw kept");
    @(posedge ref_clk_i);
    sel_bor <= 1'b1;
    pulse(7'h02);
    rd_chk(8'h58, 32'h0, "brownout to reset");
    chk({31'h0, irq_o}, 32'h0, "no brownout irq");
    @(posedge ref_clk_i);
    sel_bor <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    chk({25'h0, masked}, 32'h02, "brownout irq");
    wb(1'b1, 8'h54, 32'h22);
    rd_chk(8'h58, 32'h22, "raw and mask");
    // A write without byte lane 0 must leave the mask alone
    @(posedge ref_clk_i);
    sel <= 4'hE;
    wb(1'b1, 8'h54, 32'h0);
    sel <= 4'hF;
    rd_chk(8'h54, 32'h22, "lane 0 off");
    wb(1'b1, 8'h58, 32'hFFFFFFFF);
    rd_chk(8'h50, 32'h0, "all cleared");
    chk({31'h0, irq_o}, 32'h0, "irq idle");
    rd_chk(8'h10, 32'h0, "unmapped read");
    $display("test gating finished");
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Tests need a few hundred cycles; this cuts a hang well beyond that
  initial begin
    #80000;
    bad_count++;
    end_of_test();
  end

  initial begin
    repeat (6) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    cause <= 6'h00;
    @(posedge ref_clk_i);
    t_cause();
    t_events();
    t_gate();
    end_of_test();
  end
endmodule
